// file: rtl/lfdb_pkg.sv
package lfdb_pkg;
    // register bus geometry
    localparam int unsigned LFDB_ADDR_W = 4;
    localparam int unsigned LFDB_BYTE_W = 8;
    localparam int unsigned LFDB_DIV_W  = 12;
    localparam int unsigned LFDB_LEN_W  = 4;
    localparam int unsigned LFDB_IDX_W  = 3;
    localparam int unsigned LFDB_ID_W   = 6;
    localparam int unsigned LFDB_DEPTH  = 8;

    // register offsets (byte-wide registers on the plain port)
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_DIV_LO = 4'h0;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_DIV_HI = 4'h1;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_LEN    = 4'h2;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_ID     = 4'h3;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_SEL    = 4'h4;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_DAT    = 4'h5;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_CTRL   = 4'h6;
    localparam logic [LFDB_ADDR_W-1:0] LFDB_OFS_STAT   = 4'h7;

    // field positions
    localparam int unsigned LFDB_TXL_LO     = 4;
    localparam int unsigned LFDB_RXL_LO     = 0;
    localparam int unsigned LFDB_LEGACY_LO  = 4;
    localparam int unsigned LFDB_HOLD_BIT   = 3;
    localparam int unsigned LFDB_UART_BIT   = 0;
    localparam int unsigned LFDB_LIN13_BIT  = 1;
    localparam int unsigned LFDB_RXOK_BIT   = 0;
    localparam int unsigned LFDB_TXOK_BIT   = 1;
    localparam int unsigned LFDB_ERR_BIT    = 3;

    // reset values and length constants
    localparam logic [LFDB_BYTE_W-1:0] LFDB_BYTE_RST = 8'h00;
    localparam logic [LFDB_DIV_W-1:0]  LFDB_DIV_RST  = 12'h000;
    localparam logic [LFDB_LEN_W-1:0]  LFDB_LEN_MAX  = 4'h8;
    localparam logic [LFDB_LEN_W-1:0]  LFDB_LEN_2    = 4'h2;
    localparam logic [LFDB_LEN_W-1:0]  LFDB_LEN_4    = 4'h4;
    localparam logic [LFDB_LEN_W-1:0]  LFDB_LEN_8    = 4'h8;
    localparam logic [1:0]             LFDB_CODE_4   = 2'h2;
    localparam logic [1:0]             LFDB_CODE_8   = 2'h3;

    // one register bus request
    typedef struct packed {
        logic [LFDB_ADDR_W-1:0] addr;
        logic [LFDB_BYTE_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } lfdb_bus_req_s;

    // one byte handed over with a strobe
    typedef struct packed {
        logic                   valid;
        logic [LFDB_BYTE_W-1:0] data;
    } lfdb_byte_strobe_s;

    typedef enum {LFDB_TX_IDLE, LFDB_TX_STREAM} lfdb_tx_state_e;
endpackage

// file: rtl/lfdb_top.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module lfdb_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,       // clock
    input  wire logic             rst_i,       // async reset, high
    input  wire logic             flush_i,     // drop all content
    input  wire logic             in_valid_i,  // word offered
    output logic                  in_ready_o,  // room for a word
    input  wire logic [WIDTH-1:0] in_data_i,   // word in
    output logic                  out_valid_o, // word available
    input  wire logic             out_ready_i, // consumer takes word
    output logic [WIDTH-1:0]      out_data_o   // word out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];  // storage flops
    logic [AW-1:0]    wr_ptr_ff;       // next slot to fill
    logic [AW-1:0]    rd_ptr_ff;       // oldest slot
    logic [AW:0]      cnt_ff;          // words held
    logic             push;            // accepted write
    logic             pop;             // accepted read

    // full and empty come straight from the count, so they never lie
    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ptr_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer step with wrap, for depths that are not powers of two
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    // write pointer and storage
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            wr_ptr_ff <= '0;
        else if (flush_i)
            wr_ptr_ff <= '0;
        else if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
            wr_ptr_ff         <= step(wr_ptr_ff);
        end
    end

    // read pointer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_ptr_ff <= '0;
        else if (flush_i)
            rd_ptr_ff <= '0;
        else if (pop)
            rd_ptr_ff <= step(rd_ptr_ff);
    end

    // occupancy
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_ff <= '0;
        else if (flush_i)
            cnt_ff <= '0;
        else if (push && !pop)
            cnt_ff <= cnt_ff + 1'b1;
        else if (pop && !push)
            cnt_ff <= cnt_ff - 1'b1;
    end
endmodule // lfdb_fifo

module lfdb_top (
    input  wire logic                      ref_clk_i,      // 50 MHz i/o clock
    input  wire logic                      rst_i,          // async reset, high
    input  wire lfdb_pkg::lfdb_bus_req_s   bus_i,          // register request
    output logic [7:0]                     rdata_o,        // read data, next cycle
    output logic                           baud_tick_o,    // one pulse per sample time
    output logic                           uart_mode_o,    // 1: uart, 0: lin
    output logic [3:0]                     tx_length_o,    // effective tx bytes
    output logic [3:0]                     rx_length_o,    // effective rx bytes
    output logic [5:0]                     frame_id_o,     // effective identifier
    output logic [1:0]                     id_parity_o,    // identifier parity
    input  wire logic                      tx_start_i,     // engine starts tx response
    output logic                           tx_valid_o,     // tx byte available
    output logic [7:0]                     tx_data_o,      // tx byte
    input  wire logic                      tx_ready_i,     // engine takes tx byte
    input  wire logic                      rx_start_i,     // engine starts rx response
    input  wire lfdb_pkg::lfdb_byte_strobe_s rx_i,         // received byte strobe
    input  wire logic                      tx_done_i,      // tx complete event
    input  wire logic                      rx_done_i,      // rx complete event
    input  wire logic                      err_i,          // error event
    output logic                           uart_tx_load_o, // uart byte written, pulse
    output logic [7:0]                     uart_tx_byte_o  // uart byte to send
);
    import lfdb_pkg::*;

    // software-held configuration
    logic [LFDB_DIV_W-1:0]  div_ff;           // baud divider
    logic [LFDB_BYTE_W-1:0] len_ff;           // response length register
    logic [LFDB_ID_W-1:0]   id_ff;            // writable identifier bits
    logic [LFDB_IDX_W-1:0]  index_ff;         // buffer index
    logic                   hold_ff;          // index hold bit
    logic                   uart_ff;          // uart mode select
    logic                   lin13_ff;         // legacy identifier layout
    // flags
    logic                   tx_ok_ff;         // tx complete flag
    logic                   rx_ok_ff;         // rx complete flag
    logic                   err_ff;           // error summary flag
    // data path
    logic [LFDB_BYTE_W-1:0] buf_ff [LFDB_DEPTH]; // response buffer
    logic [LFDB_BYTE_W-1:0] uart_rx_ff;       // uart receive register
    logic [LFDB_BYTE_W-1:0] uart_tx_ff;       // uart transmit register
    logic                   uart_load_ff;     // uart write pulse
    logic [LFDB_BYTE_W-1:0] rdata_ff;         // read data
    logic [LFDB_DIV_W-1:0]  baud_cnt_ff;      // divider counter
    logic                   tick_ff;          // baud tick
    logic [LFDB_LEN_W-1:0]  tx_len_ff;        // effective tx length out
    logic [LFDB_LEN_W-1:0]  rx_len_ff;        // effective rx length out
    logic [LFDB_ID_W-1:0]   fid_ff;           // effective id out
    logic [1:0]             par_ff;           // parity out
    lfdb_tx_state_e         tx_state_ff;      // tx streaming state
    logic [LFDB_IDX_W-1:0]  tx_ptr_ff;        // next byte to stream
    logic [LFDB_LEN_W-1:0]  tx_left_ff;       // bytes still to stream
    logic [LFDB_IDX_W-1:0]  rx_ptr_ff;        // next slot to fill
    logic [LFDB_LEN_W-1:0]  rx_left_ff;       // bytes still expected

    // decoded strobes
    logic                   wr_div_lo, wr_div_hi, wr_len, wr_id, wr_sel;
    logic                   wr_dat, rd_dat, wr_ctrl, wr_stat;
    logic                   lin_dat_acc;      // data access in lin mode
    logic                   rx_wr;            // engine byte into buffer
    logic [LFDB_LEN_W-1:0]  tx_len_eff;       // tx length after clamp/legacy
    logic [LFDB_LEN_W-1:0]  rx_len_eff;       // rx length after clamp/legacy
    logic [LFDB_ID_W-1:0]   fid_eff;          // identifier after layout
    logic                   fifo_in_valid;    // streaming offers a byte
    logic                   fifo_in_ready;    // fifo has room
    logic [LFDB_BYTE_W-1:0] rd_mux;           // register read value

    // address decode, used for every write strobe and the data read strobe
    function automatic logic hit(input lfdb_bus_req_s r, input logic [LFDB_ADDR_W-1:0] a);
        hit = (r.addr == a);
    endfunction

    // length field clamp, shared by tx and rx
    function automatic logic [LFDB_LEN_W-1:0] clamp(input logic [LFDB_LEN_W-1:0] l);
        clamp = (l > LFDB_LEN_MAX) ? LFDB_LEN_MAX : l;
    endfunction

    // legacy two-bit length code to byte count
    function automatic logic [LFDB_LEN_W-1:0] legacy_len(input logic [1:0] c);
        unique case (c)
            LFDB_CODE_8: legacy_len = LFDB_LEN_8;
            LFDB_CODE_4: legacy_len = LFDB_LEN_4;
            default:     legacy_len = LFDB_LEN_2;
        endcase
    endfunction

    assign wr_div_lo   = bus_i.wr && hit(bus_i, LFDB_OFS_DIV_LO);
    assign wr_div_hi   = bus_i.wr && hit(bus_i, LFDB_OFS_DIV_HI);
    assign wr_len      = bus_i.wr && hit(bus_i, LFDB_OFS_LEN);
    assign wr_id       = bus_i.wr && hit(bus_i, LFDB_OFS_ID);
    assign wr_sel      = bus_i.wr && hit(bus_i, LFDB_OFS_SEL);
    assign wr_dat      = bus_i.wr && hit(bus_i, LFDB_OFS_DAT);
    assign rd_dat      = bus_i.rd && hit(bus_i, LFDB_OFS_DAT);
    assign wr_ctrl     = bus_i.wr && hit(bus_i, LFDB_OFS_CTRL);
    assign wr_stat     = bus_i.wr && hit(bus_i, LFDB_OFS_STAT);
    assign lin_dat_acc = (wr_dat || rd_dat) && !uart_ff;

    // legacy layout takes length from the id code, else the clamped fields
    assign tx_len_eff = lin13_ff ? legacy_len(id_ff[LFDB_LEGACY_LO +: 2])
                                 : clamp(len_ff[LFDB_TXL_LO +: LFDB_LEN_W]);
    assign rx_len_eff = lin13_ff ? legacy_len(id_ff[LFDB_LEGACY_LO +: 2])
                                 : clamp(len_ff[LFDB_RXL_LO +: LFDB_LEN_W]);
    assign fid_eff    = lin13_ff ? {2'h0, id_ff[3:0]}
                                 : id_ff;

    // divider and mode configuration
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_ff   <= LFDB_DIV_RST;
            uart_ff  <= 1'b0;
            lin13_ff <= 1'b0;
        end
        else
        begin
            if (wr_div_lo)
                div_ff[7:0] <= bus_i.wdata;
            if (wr_div_hi)
                div_ff[LFDB_DIV_W-1:8] <= bus_i.wdata[3:0];
            if (wr_ctrl)
            begin
                uart_ff  <= bus_i.wdata[LFDB_UART_BIT];
                lin13_ff <= bus_i.wdata[LFDB_LIN13_BIT];
            end
        end
    end

    // sample-time tick: one pulse every divider+1 clocks
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            baud_cnt_ff <= LFDB_DIV_RST;
            tick_ff     <= 1'b0;
        end
        else if (baud_cnt_ff >= div_ff) // also recovers when divider shrinks
        begin
            baud_cnt_ff <= LFDB_DIV_RST;
            tick_ff     <= 1'b1;
        end
        else
        begin
            baud_cnt_ff <= baud_cnt_ff + 1'b1;
            tick_ff     <= 1'b0;
        end
    end

    // length and identifier registers; parity bits are never written
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            len_ff <= LFDB_BYTE_RST;
            id_ff  <= '0;
        end
        else
        begin
            if (wr_len)
                len_ff <= bus_i.wdata;
            if (wr_id)
                id_ff <= bus_i.wdata[LFDB_ID_W-1:0];
        end
    end

    // buffer index: a select write wins over auto advance
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            index_ff <= '0;
            hold_ff  <= 1'b0;
        end
        else if (wr_sel)
        begin
            // reserved upper bits are simply not stored
            index_ff <= bus_i.wdata[LFDB_IDX_W-1:0];
            hold_ff  <= bus_i.wdata[LFDB_HOLD_BIT];
        end
        else if (lin_dat_acc && !hold_ff)
            index_ff <= index_ff + 1'b1; // natural wrap seven to zero
    end

    // engine bytes land at the receive pointer in lin mode
    assign rx_wr = rx_i.valid && !uart_ff && (rx_left_ff != '0);

    // response buffer; the engine wins a same-slot clash since it cannot retry
    for (genvar gi = 0; gi < LFDB_DEPTH; gi++)
    begin : g_buf
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                buf_ff[gi] <= LFDB_BYTE_RST;
            else if (rx_wr && rx_ptr_ff == LFDB_IDX_W'(gi))
                buf_ff[gi] <= rx_i.data;
            else if (wr_dat && !uart_ff && index_ff == LFDB_IDX_W'(gi))
                buf_ff[gi] <= bus_i.wdata;
        end
    end

    // receive pointer for lin responses
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_ptr_ff  <= '0;
            rx_left_ff <= '0;
        end
        else if (rx_start_i)
        begin
            rx_ptr_ff  <= '0;
            rx_left_ff <= rx_len_eff;
        end
        else if (rx_wr)
        begin
            rx_ptr_ff  <= rx_ptr_ff + 1'b1;
            rx_left_ff <= rx_left_ff - 1'b1;
        end
    end

    // uart mode: single unbuffered registers, no fifo
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            uart_rx_ff   <= LFDB_BYTE_RST;
            uart_tx_ff   <= LFDB_BYTE_RST;
            uart_load_ff <= 1'b0;
        end
        else
        begin
            if (rx_i.valid && uart_ff)
                uart_rx_ff <= rx_i.data;
            if (wr_dat && uart_ff)
                uart_tx_ff <= bus_i.wdata;
            uart_load_ff <= wr_dat && uart_ff;
        end
    end

    // tx streaming: buffer bytes into the fifo, stalled by fifo back-pressure
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_state_ff <= LFDB_TX_IDLE;
            tx_ptr_ff   <= '0;
            tx_left_ff  <= '0;
        end
        else if (tx_start_i && !uart_ff)
        begin
            tx_ptr_ff   <= '0;
            tx_left_ff  <= tx_len_eff;
            tx_state_ff <= (tx_len_eff == '0) ? LFDB_TX_IDLE : LFDB_TX_STREAM;
        end
        else
        begin
            unique case (tx_state_ff)
                LFDB_TX_IDLE:
                    tx_state_ff <= LFDB_TX_IDLE;
                LFDB_TX_STREAM:
                    if (fifo_in_ready)
                    begin
                        tx_ptr_ff  <= tx_ptr_ff + 1'b1;
                        tx_left_ff <= tx_left_ff - 1'b1;
                        if (tx_left_ff == 4'h1)
                            tx_state_ff <= LFDB_TX_IDLE;
                    end
            endcase
        end
    end

    assign fifo_in_valid = (tx_state_ff == LFDB_TX_STREAM);

    // eight-word queue between buffer and engine; a new start drops leftovers
    lfdb_fifo #(
        .WIDTH (LFDB_BYTE_W),
        .DEPTH (LFDB_DEPTH)
    ) u_tx_fifo (
        .clk_i       (ref_clk_i),
        .rst_i       (rst_i),
        .flush_i     (tx_start_i && !uart_ff),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (buf_ff[tx_ptr_ff]),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o)
    );

    // flags: an event in the clearing cycle survives
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_ok_ff <= 1'b0;
            rx_ok_ff <= 1'b0;
            err_ff   <= 1'b0;
        end
        else
        begin
            if (tx_done_i)
                tx_ok_ff <= 1'b1;
            else if ((wr_stat && bus_i.wdata[LFDB_TXOK_BIT]) || (wr_dat && uart_ff))
                tx_ok_ff <= 1'b0;
            if (rx_done_i)
                rx_ok_ff <= 1'b1;
            else if ((wr_stat && bus_i.wdata[LFDB_RXOK_BIT]) || (rd_dat && uart_ff))
                rx_ok_ff <= 1'b0;
            if (err_i)
                err_ff <= 1'b1;
            else if ((wr_stat && bus_i.wdata[LFDB_ERR_BIT]) || (rd_dat && uart_ff))
                err_ff <= 1'b0;
        end
    end

    // read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_mux = LFDB_BYTE_RST;
        unique case (bus_i.addr)
            LFDB_OFS_DIV_LO: rd_mux = div_ff[7:0];
            LFDB_OFS_DIV_HI: rd_mux = {4'h0, div_ff[LFDB_DIV_W-1:8]};
            LFDB_OFS_LEN:    rd_mux = len_ff;
            LFDB_OFS_ID:     rd_mux = {par_ff, id_ff};
            LFDB_OFS_SEL:    rd_mux = {4'h0, hold_ff, index_ff};
            LFDB_OFS_DAT:    rd_mux = uart_ff ? uart_rx_ff : buf_ff[index_ff];
            LFDB_OFS_CTRL:   rd_mux = {6'h00, lin13_ff, uart_ff};
            LFDB_OFS_STAT:   rd_mux = {4'h0, err_ff, 1'b0, tx_ok_ff, rx_ok_ff};
            default:         rd_mux = LFDB_BYTE_RST;
        endcase
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_ff <= LFDB_BYTE_RST;
        else
            rdata_ff <= bus_i.rd ? rd_mux : LFDB_BYTE_RST;
    end

    // registered view for the engine; one cycle behind the registers
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_len_ff <= '0;
            rx_len_ff <= '0;
            fid_ff    <= '0;
            par_ff    <= 2'h0;
        end
        else
        begin
            tx_len_ff <= tx_len_eff;
            rx_len_ff <= rx_len_eff;
            fid_ff    <= fid_eff;
            // protected identifier parity over the six identifier bits
            par_ff[0] <= id_ff[0] ^ id_ff[1] ^ id_ff[2] ^ id_ff[4];
            par_ff[1] <= ~(id_ff[1] ^ id_ff[3] ^ id_ff[4] ^ id_ff[5]);
        end
    end

    assign rdata_o        = rdata_ff;
    assign baud_tick_o    = tick_ff;
    assign uart_mode_o    = uart_ff;
    assign tx_length_o    = tx_len_ff;
    assign rx_length_o    = rx_len_ff;
    assign frame_id_o     = fid_ff;
    assign id_parity_o    = par_ff;
    assign uart_tx_load_o = uart_load_ff;
    assign uart_tx_byte_o = uart_tx_ff;
endmodule // lfdb_top

// file: rtl/HANDOVER_unused_placeholder_removed.sv
`timescale 1ns/1ps

// file: verification/lfdb_top_chk.sv
`timescale 1ns/1ps
module lfdb_chk
    import lfdb_pkg::*;
(
    input logic                    ref_clk_i,      // clock
    input logic                    rst_i,          // reset
    input lfdb_pkg::lfdb_bus_req_s bus_i,          // request
    input logic [7:0]              rdata_o,        // read data
    input logic                    uart_mode_o,    // mode
    input logic [3:0]              tx_length_o,    // tx count
    input logic [3:0]              rx_length_o,    // rx count
    input logic                    tx_start_i,     // tx start
    input logic                    tx_valid_o,     // tx valid
    input logic [7:0]              tx_data_o,      // tx byte
    input logic                    tx_ready_i,     // tx pop
    input logic                    uart_tx_load_o, // load pulse
    input logic [7:0]              uart_tx_byte_o  // uart byte
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // data-port write in uart mode
    sequence s_uart_wr;
        bus_i.wr && bus_i.addr == LFDB_OFS_DAT && uart_mode_o;
    endsequence
    // lin start with bytes to send
    sequence s_lin_start;
        tx_start_i && !uart_mode_o && tx_length_o != 4'h0;
    endsequence
    a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("stray read data");
    a_tx_clamp: assert property (tx_length_o <= LFDB_LEN_MAX)
        else $error("tx over eight");
    a_rx_clamp: assert property (rx_length_o <= LFDB_LEN_MAX)
        else $error("rx over eight");
    a_uart_load: assert property (s_uart_wr |=> uart_tx_load_o
        && uart_tx_byte_o == $past(bus_i.wdata)) else $error("no uart load");
    a_load_cause: assert property (uart_tx_load_o |-> $past(bus_i.wr)
        && $past(bus_i.addr) == LFDB_OFS_DAT) else $error("stray load");
    a_byte_hold: assert property (!uart_tx_load_o |-> $stable(uart_tx_byte_o))
        else $error("uart byte moved");
    a_tx_first: assert property (s_lin_start |-> ##2 tx_valid_o)
        else $error("tx late");
    // a stalled head waits: losing it breaks the frame
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i && !tx_start_i
        |=> tx_valid_o && $stable(tx_data_o)) else $error("tx head lost");
endmodule // lfdb_chk

// file: verification/lfdb_engine_model.sv
`timescale 1ns/1ps
module lfdb_engine_model
    import lfdb_pkg::*;
(
    input  wire logic                   clk_i,      // clock
    input  wire logic                   tx_valid_i, // byte offered
    input  wire logic [7:0]             tx_data_i,  // offered byte
    input  wire logic                   stall_i,    // hold off pops
    output logic                        tx_ready_o, // pop
    output lfdb_pkg::lfdb_byte_strobe_s rx_o        // received byte
);
    logic [7:0] got [$];     // popped bytes in order
    logic       ph_ff = 1'b0; // ready every other cycle
    // byte moves on valid and ready
    always_ff @(posedge clk_i)
    begin
        ph_ff <= ~ph_ff;
        if (tx_valid_i && tx_ready_o)
            got.push_back(tx_data_i);
    end
    assign tx_ready_o = !stall_i && ph_ff;
    initial rx_o = '{valid: 1'b0, data: 8'hC3};
    // one byte a cycle; junk data between strobes
    task automatic send(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            rx_o <= '{valid: 1'b1, data: base + 8'(i)};
        end
        @(posedge clk_i);
        rx_o <= '{valid: 1'b0, data: ~rx_o.data};
    endtask
endmodule // lfdb_engine_model

// file: verification/lfdb_top_test.sv
`timescale 1ns/1ps
module lfdb_top_test;
    import lfdb_pkg::*;
    logic              clk = 1'b0;     // i/o clock
    logic              rst = 1'b1;     // reset
    lfdb_bus_req_s     bus = '0;       // register request
    logic              txs = 1'b0;     // tx response start
    logic              rxs = 1'b0;     // rx response start
    logic              txd = 1'b0, rxd = 1'b0, err = 1'b0; // engine events
    logic              stall = 1'b1;   // engine holds pops
    logic [7:0]        rdata, txb, ub;
    logic [3:0]        txl, rxl;
    logic [5:0]        fid;
    logic [1:0]        par;
    logic              tick, um, txv, txr, ul;
    lfdb_byte_strobe_s rx;
    int                n_mismatch = 0, comparisons = 0, cyc = 0, ticks = 0;
    logic [15:0]       len_tab [4] = '{16'hA383, 16'h5F58, 16'hFF88, 16'h0000};
    logic [3:0]        leg [4] = '{4'h2, 4'h2, 4'h4, 4'h8};
    logic [3:0]        ofs [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h7, 4'h9};
    lfdb_top i_dut (.ref_clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata),
        .baud_tick_o(tick), .uart_mode_o(um), .tx_length_o(txl), .rx_length_o(rxl),
        .frame_id_o(fid), .id_parity_o(par), .tx_start_i(txs), .tx_valid_o(txv),
        .tx_data_o(txb), .tx_ready_i(txr), .rx_start_i(rxs), .rx_i(rx), .tx_done_i(txd),
        .rx_done_i(rxd), .err_i(err), .uart_tx_load_o(ul), .uart_tx_byte_o(ub));
    lfdb_engine_model i_eng (.clk_i(clk), .tx_valid_i(txv), .tx_data_i(txb),
        .stall_i(stall), .tx_ready_o(txr), .rx_o(rx));
    always #10 clk = ~clk;
    // hang guard and baud tick tally
    always @(posedge clk)
    begin
        cyc++;
        ticks += (tick === 1'b1);
        if (cyc == 4000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // data stand one cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check(rdata, e);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check(par, 2'b10);
        foreach (ofs[i])
            rc(ofs[i], 8'h00);
        foreach (len_tab[i])
        begin
            wr(LFDB_OFS_LEN, len_tab[i][15:8]);
            rc(LFDB_OFS_LEN, len_tab[i][15:8]);
            check(txl, len_tab[i][7:4]);
            check(rxl, len_tab[i][3:0]);
        end
        $display("lengths done");
        wr(LFDB_OFS_ID, 8'hFF);
        rc(LFDB_OFS_ID, 8'hBF);
        check(fid, 6'h3F);
        wr(LFDB_OFS_CTRL, 8'h02);
        for (int c = 0; c < 4; c++)
        begin
            wr(LFDB_OFS_ID, {2'b00, 2'(c), 4'h5});
            @(posedge clk);
            #1 check(txl, leg[c]);
            check(fid, 6'h05);
        end
        wr(LFDB_OFS_CTRL, 8'h00);
        $display("identifier done");
        wr(LFDB_OFS_SEL, 8'h00);
        for (int i = 0; i < 8; i++)
            wr(LFDB_OFS_DAT, 8'h10 + 8'(i));
        rc(LFDB_OFS_DAT, 8'h10);
        wr(LFDB_OFS_SEL, 8'h0B);
        rc(LFDB_OFS_DAT, 8'h13);
        rc(LFDB_OFS_DAT, 8'h13);
        // stalled engine: fifo fills first
        wr(LFDB_OFS_LEN, 8'hF2);
        @(posedge clk);
        txs <= 1'b1;
        @(posedge clk);
        txs <= 1'b0;
        repeat (20) @(posedge clk);
        stall <= 1'b0;
        for (int w = 0; w < 100 && i_eng.got.size() < 8; w++)
            @(posedge clk);
        check(12'(i_eng.got.size()), 12'h008);
        foreach (i_eng.got[i])
            check(i_eng.got[i], 8'h10 + 8'(i));
        @(posedge clk);
        rxs <= 1'b1;
        @(posedge clk);
        rxs <= 1'b0;
        i_eng.send(3, 8'hA0);
        wr(LFDB_OFS_SEL, 8'h00);
        rc(LFDB_OFS_DAT, 8'hA0);
        rc(LFDB_OFS_DAT, 8'hA1);
        rc(LFDB_OFS_DAT, 8'h12);
        $display("buffer done");
        wr(LFDB_OFS_CTRL, 8'h01);
        @(posedge clk);
        txd <= 1'b1;
        @(posedge clk);
        txd <= 1'b0;
        wr(LFDB_OFS_DAT, 8'h5A);
        #1 check(ub, 8'h5A);
        rc(LFDB_OFS_STAT, 8'h00);
        i_eng.send(1, 8'h3C);
        rxd <= 1'b1;
        err <= 1'b1;
        @(posedge clk);
        rxd <= 1'b0;
        err <= 1'b0;
        rc(LFDB_OFS_STAT, 8'h09);
        rc(LFDB_OFS_DAT, 8'h3C);
        rc(LFDB_OFS_STAT, 8'h00);
        rc(LFDB_OFS_SEL, 8'h03);
        $display("uart done");
        wr(LFDB_OFS_DIV_HI, 8'h01);
        wr(LFDB_OFS_DIV_LO, 8'h03);
        repeat (300) @(posedge clk);
        #1 ticks = 0;
        repeat (520) @(posedge clk);
        #1 check(ticks, 2);
        $display("baud done");
        conclude();
    end
endmodule // lfdb_top_test
bind lfdb_top lfdb_chk i_chk (.*);
